/* File: core/spcs_pkg.sv */
package spcs_pkg;

    // Register offsets on the local port
    localparam int          ADDR_W       = 3;
    localparam logic [2:0]  OFS_FORMAT   = 3'h0;
    localparam logic [2:0]  OFS_DIVISOR  = 3'h1;
    localparam logic [2:0]  OFS_CONTROL  = 3'h2;
    localparam logic [2:0]  OFS_TX_HOLD  = 3'h3;
    localparam logic [2:0]  OFS_STATUS   = 3'h4;
    localparam logic [2:0]  OFS_RX_HOLD  = 3'h5;

    // format_select fields
    localparam int FMT_SYNC      = 7;
    localparam int FMT_MARK_MODE = 2;
    localparam int FMT_PS_HI     = 1;
    localparam int FMT_PS_LO     = 0;

    // serial_control fields
    localparam int CTL_TX_ON     = 5;
    localparam int CTL_RX_ON     = 4;
    localparam int CTL_ADDR_WAIT = 3;
    localparam int CTL_TXD_IE    = 2;
    localparam int CTL_CLK_HI    = 1;
    localparam int CTL_CLK_LO    = 0;

    // status_flags fields
    localparam int ST_TX_EMPTY   = 7;
    localparam int ST_RX_FULL    = 6;
    localparam int ST_OVERRUN    = 5;
    localparam int ST_FRAMING    = 4;
    localparam int ST_PARITY     = 3;
    localparam int ST_TX_DONE    = 2;
    localparam int ST_RX_MARK    = 1;
    localparam int ST_TX_MARK    = 0;
    localparam int ST_CLR_LO     = 3;

    // Values after reset
    localparam logic [7:0]  RST_FORMAT   = 8'h00;
    localparam logic [7:0]  RST_CONTROL  = 8'h00;
    localparam logic [7:0]  RST_DIVISOR  = 8'hff;
    localparam logic [7:0]  RST_TX_HOLD  = 8'hff;
    localparam logic [7:0]  RST_RX_HOLD  = 8'h00;
    localparam logic [7:0]  RST_STATUS   = 8'h84;

    // Clock-source codes
    localparam logic [1:0]  CS_INT       = 2'b00;
    localparam logic [1:0]  CS_INT_OUT   = 2'b01;
    localparam logic [1:0]  CS_EXT       = 2'b10;

    // Prescaler wrap values: 1, 4, 16, 64 system clocks
    localparam logic [5:0]  PS_LAST_0    = 6'h00;
    localparam logic [5:0]  PS_LAST_1    = 6'h03;
    localparam logic [5:0]  PS_LAST_2    = 6'h0f;
    localparam logic [5:0]  PS_LAST_3    = 6'h3f;

    // Base ticks per bit: 32 asynchronous, 4 clock-synchronous
    localparam logic [4:0]  ASYNC_LAST   = 5'h1f;
    localparam logic [4:0]  ASYNC_HALF   = 5'h0f;
    localparam logic [4:0]  SYNC_LAST    = 5'h03;
    localparam logic [4:0]  SYNC_HALF    = 5'h01;

endpackage : spcs_pkg

/* File: core/spcs_sync2.sv */
`timescale 1ns/1ps
`default_nettype none
module spcs_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // Two-stage synchroniser, reset to the idle-high pin level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '1;
            q        <= '1;
        end else if (ce) begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule : spcs_sync2
`default_nettype wire

/* File: core/spcs_rate_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module spcs_rate_gen
    import spcs_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic       run,
    input  wire logic       sync_mode,
    input  wire logic [1:0] prescale,
    input  wire logic [7:0] divisor,
    output logic            tick,
    output logic            clk_level
);
    logic [5:0] pre_reg, pre_next, pre_last;
    logic [7:0] div_reg, div_next;
    logic [4:0] ph_reg, ph_next, ph_last, ph_half;
    logic       tick_next, clk_next, pre_hit, base;

    // Prescaler, divisor and bit phase
    always_comb begin
        unique case (prescale)
            2'b00: pre_last = PS_LAST_0;
            2'b01: pre_last = PS_LAST_1;
            2'b10: pre_last = PS_LAST_2;
            2'b11: pre_last = PS_LAST_3;
        endcase
        ph_last   = sync_mode ? SYNC_LAST : ASYNC_LAST;
        ph_half   = sync_mode ? SYNC_HALF : ASYNC_HALF;
        pre_hit   = (pre_reg == pre_last);
        base      = pre_hit && (div_reg == 8'h00);
        pre_next  = (!run || pre_hit) ? 6'h00 : pre_reg + 6'h01;
        div_next  = div_reg;
        if (!run || base)
            div_next = divisor;
        else if (pre_hit)
            div_next = div_reg - 8'h01;
        ph_next   = ph_reg;
        if (!run)
            ph_next = 5'h00;
        else if (base)
            ph_next = (ph_reg == ph_last) ? 5'h00 : ph_reg + 5'h01;
        // Async: 16 ticks per bit; sync: one tick per bit
        tick_next = base && (sync_mode ? (ph_reg == ph_last) : ph_reg[0]);
        clk_next  = clk_level;
        if (!run)
            clk_next = 1'b1;
        else if (base && (ph_reg == ph_half || ph_reg == ph_last))
            clk_next = ~clk_level;
    end

    // Registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_reg   <= 6'h00;
            div_reg   <= RST_DIVISOR;
            ph_reg    <= 5'h00;
            tick      <= 1'b0;
            clk_level <= 1'b1;
        end else if (ce) begin
            pre_reg   <= pre_next;
            div_reg   <= div_next;
            ph_reg    <= ph_next;
            tick      <= tick_next;
            clk_level <= clk_next;
        end
    end
endmodule : spcs_rate_gen
`default_nettype wire

/* File: core/spcs_top.sv */
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module spcs_top
    import spcs_pkg::*;
(
    input  wire logic              SYS_CLK,
    input  wire logic              RST_N,
    input  wire logic              CE,
    input  wire logic [ADDR_W-1:0] ADDR,
    input  wire logic [7:0]        WDATA,
    input  wire logic              WR,
    input  wire logic              RD,
    output logic      [7:0]        RDATA,
    output logic      [7:0]        TX_DATA,
    output logic                   TX_DATA_VALID,
    output logic                   TX_MARKER,
    output logic                   TX_ENABLE,
    input  wire logic              TX_LOAD,
    input  wire logic              TX_LAST_BIT,
    output logic                   RX_ENABLE,
    input  wire logic              RX_DONE,
    input  wire logic [7:0]        RX_DATA,
    input  wire logic              RX_MARK_IN,
    input  wire logic              RX_FRAME_ERR,
    input  wire logic              RX_PARITY_ERR,
    output logic                   SYNC_MODE,
    output logic                   MARK_MODE,
    output logic                   BIT_TICK,
    output logic                   TX_DONE_IRQ,
    input  wire logic              SCK_IN,
    output logic                   SCK_OUT,
    output logic                   SCK_OE
);
    // Register file state
    logic [7:0] fmt_reg,   fmt_next;
    logic [7:0] ctl_reg,   ctl_next;
    logic [7:0] div_reg,   div_next;
    logic [7:0] txh_reg,   txh_next;
    logic [7:0] rxh_reg,   rxh_next;
    logic [7:0] st_reg,    st_next;
    logic [7:0] seen_reg,  seen_next;
    logic [7:0] rdata_reg, rdata_next;
    logic       valid_reg, valid_next;
    logic       irq_reg,   irq_next;

    // Clock path state
    logic       tick_reg,  tick_next;
    logic       sck_o_reg, sck_o_next;
    logic       sck_e_reg, sck_e_next;
    logic       sck_prev_reg;
    logic       sck_s;
    logic       gen_tick,  gen_clk;

    // Decoded strobes and events
    logic       wr_fmt, wr_div, wr_ctl, wr_txh, wr_st;
    logic       rd_st, rd_rxh;
    logic       is_sync, mp_wait;
    logic       rx_evt, rx_skip, rx_take, rx_wake, rx_err_any;
    logic       frm_hit, par_hit;
    logic [7:0] set_vec, clr_vec;
    logic       tx_clr;
    logic [1:0] cs;
    logic       int_ok, ext_ok, gen_run;

    // Pin input crosses into the system clock domain
    spcs_sync2 #(
        .W     (1)
    ) u_sck_sync (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .ce    (CE),
        .d     (SCK_IN),
        .q     (sck_s)
    );

    // Internal rate generator
    spcs_rate_gen u_rate (
        .clk       (SYS_CLK),
        .rst_n     (RST_N),
        .ce        (CE),
        .run       (gen_run),
        .sync_mode (is_sync),
        .prescale  (fmt_reg[FMT_PS_HI:FMT_PS_LO]),
        .divisor   (div_reg),
        .tick      (gen_tick),
        .clk_level (gen_clk)
    );

    // Address decode of the local port
    always_comb begin
        wr_fmt = WR && (ADDR == OFS_FORMAT);
        wr_div = WR && (ADDR == OFS_DIVISOR);
        wr_ctl = WR && (ADDR == OFS_CONTROL);
        wr_txh = WR && (ADDR == OFS_TX_HOLD);
        wr_st  = WR && (ADDR == OFS_STATUS);
        rd_st  = RD && (ADDR == OFS_STATUS);
        rd_rxh = RD && (ADDR == OFS_RX_HOLD);
    end

    // Receive event qualification
    always_comb begin
        is_sync    = fmt_reg[FMT_SYNC];
        mp_wait    = ctl_reg[CTL_ADDR_WAIT] && fmt_reg[FMT_MARK_MODE] && !is_sync;
        rx_err_any = st_reg[ST_OVERRUN] | st_reg[ST_FRAMING] | st_reg[ST_PARITY];
        // Reception stalls while an error flag is pending
        rx_evt     = RX_DONE && ctl_reg[CTL_RX_ON] && !rx_err_any;
        rx_skip    = rx_evt && mp_wait && !RX_MARK_IN;
        rx_wake    = rx_evt && mp_wait && RX_MARK_IN;
        rx_take    = rx_evt && !rx_skip;
        frm_hit    = rx_take && !is_sync && RX_FRAME_ERR;
        par_hit    = rx_take && !is_sync && RX_PARITY_ERR;
    end

    // Flag set and clear terms; set always wins over clear
    always_comb begin
        set_vec              = 8'h00;
        set_vec[ST_TX_EMPTY] = !ctl_reg[CTL_TX_ON] || TX_LOAD;
        set_vec[ST_RX_FULL]  = rx_take && !st_reg[ST_RX_FULL]
                               && !frm_hit && !par_hit;
        set_vec[ST_OVERRUN]  = rx_take && st_reg[ST_RX_FULL];
        set_vec[ST_FRAMING]  = frm_hit;
        set_vec[ST_PARITY]   = par_hit;
        set_vec[ST_TX_DONE]  = !ctl_reg[CTL_TX_ON]
                               || (TX_LAST_BIT && st_reg[ST_TX_EMPTY]);
        clr_vec = 8'h00;
        // Write of 0 clears only bits 3 to 7 that were last read as 1; bit 2 clears along with bit 7
        for (int b = ST_CLR_LO; b < 8; b++) begin
            clr_vec[b] = wr_st && !WDATA[b] && seen_reg[b];
        end
        tx_clr               = clr_vec[ST_TX_EMPTY] || wr_txh;
        clr_vec[ST_TX_EMPTY] = tx_clr;
        clr_vec[ST_TX_DONE]  = tx_clr;
        clr_vec[ST_RX_FULL]  = clr_vec[ST_RX_FULL] || rd_rxh;
    end

    // Status register next value
    always_comb begin
        st_next = (st_reg & ~clr_vec) | set_vec;
        if (rx_evt)
            st_next[ST_RX_MARK] = RX_MARK_IN;
        if (wr_st)
            st_next[ST_TX_MARK] = WDATA[ST_TX_MARK];
        seen_next = seen_reg;
        if (rd_st)
            seen_next = st_reg;
        else if (wr_st)
            seen_next = 8'h00;
    end

    // Control, format, divisor and hold registers
    always_comb begin
        fmt_next = wr_fmt ? WDATA : fmt_reg;
        div_next = wr_div ? WDATA : div_reg;
        ctl_next = wr_ctl ? WDATA : ctl_reg;
        if (rx_wake)
            ctl_next[CTL_ADDR_WAIT] = 1'b0;
        txh_next = wr_txh ? WDATA : txh_reg;
        // Data is kept on error, lost on overrun
        rxh_next = (rx_take && !st_reg[ST_RX_FULL]) ? RX_DATA : rxh_reg;
        valid_next = !st_next[ST_TX_EMPTY];
        irq_next   = st_next[ST_TX_DONE] && ctl_next[CTL_TXD_IE];
    end

    // Read data, present only in the cycle after the strobe
    always_comb begin
        rdata_next = 8'h00;
        if (RD) begin
            unique case (ADDR)
                OFS_FORMAT:  rdata_next = fmt_reg;
                OFS_DIVISOR: rdata_next = div_reg;
                OFS_CONTROL: rdata_next = ctl_reg;
                OFS_TX_HOLD: rdata_next = txh_reg;
                OFS_STATUS:  rdata_next = st_reg;
                OFS_RX_HOLD: rdata_next = rxh_reg;
                default:     rdata_next = 8'h00;
            endcase
        end
    end

    // Clock source selection and pin drive
    always_comb begin
        cs = ctl_reg[CTL_CLK_HI:CTL_CLK_LO];
        if (is_sync) begin
            int_ok     = (cs == CS_INT);
            sck_e_next = (cs == CS_INT);
        end else begin
            int_ok     = (cs == CS_INT) || (cs == CS_INT_OUT);
            sck_e_next = (cs == CS_INT_OUT);
        end
        ext_ok     = (cs == CS_EXT);
        gen_run    = int_ok && (ctl_reg[CTL_TX_ON] || ctl_reg[CTL_RX_ON]);
        sck_o_next = gen_clk;
        // External clock: each rising edge is one tick
        if (int_ok)
            tick_next = gen_tick;
        else if (ext_ok)
            tick_next = sck_s && !sck_prev_reg;
        else
            tick_next = 1'b0;
    end

    // Register bank
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            fmt_reg      <= RST_FORMAT;
            ctl_reg      <= RST_CONTROL;
            div_reg      <= RST_DIVISOR;
            txh_reg      <= RST_TX_HOLD;
            rxh_reg      <= RST_RX_HOLD;
            st_reg       <= RST_STATUS;
            seen_reg     <= 8'h00;
            rdata_reg    <= 8'h00;
            valid_reg    <= 1'b0;
            irq_reg      <= 1'b0;
            tick_reg     <= 1'b0;
            sck_o_reg    <= 1'b1;
            sck_e_reg    <= 1'b0;
            sck_prev_reg <= 1'b1;  // Idle-high pin, no false edge
        end else if (CE) begin
            fmt_reg      <= fmt_next;
            ctl_reg      <= ctl_next;
            div_reg      <= div_next;
            txh_reg      <= txh_next;
            rxh_reg      <= rxh_next;
            st_reg       <= st_next;
            seen_reg     <= seen_next;
            rdata_reg    <= rdata_next;
            valid_reg    <= valid_next;
            irq_reg      <= irq_next;
            tick_reg     <= tick_next;
            sck_o_reg    <= sck_o_next;
            sck_e_reg    <= sck_e_next;
            sck_prev_reg <= sck_s;
        end
    end

    // Outputs straight from flip-flops
    assign RDATA         = rdata_reg;
    assign TX_DATA       = txh_reg;
    assign TX_DATA_VALID = valid_reg;
    assign TX_MARKER     = st_reg[ST_TX_MARK];
    assign TX_ENABLE     = ctl_reg[CTL_TX_ON];
    assign RX_ENABLE     = ctl_reg[CTL_RX_ON];
    assign SYNC_MODE     = fmt_reg[FMT_SYNC];
    assign MARK_MODE     = fmt_reg[FMT_MARK_MODE];
    assign BIT_TICK      = tick_reg;
    assign TX_DONE_IRQ   = irq_reg;
    assign SCK_OUT       = sck_o_reg;
    assign SCK_OE        = sck_e_reg;
endmodule : spcs_top
`default_nettype wire

/* File: tb/spcs_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module spcs_assertions
    import spcs_pkg::*;
(
    input wire logic              SYS_CLK,
    input wire logic              RST_N,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [7:0]        WDATA,
    input wire logic              WR,
    input wire logic              RD,
    input wire logic [7:0]        RDATA,
    input wire logic [7:0]        TX_DATA,
    input wire logic              TX_DATA_VALID,
    input wire logic              TX_ENABLE,
    input wire logic              TX_LOAD,
    input wire logic              RX_ENABLE,
    input wire logic              SYNC_MODE,
    input wire logic              BIT_TICK,
    input wire logic              TX_DONE_IRQ,
    input wire logic              SCK_OUT,
    input wire logic              SCK_OE
);
    logic [7:0] ctl_reg;
    logic [7:0] ctl_next;

    // Shadow of what software last wrote to the control register
    always_comb begin
        ctl_next = ctl_reg;
        if (WR && ADDR == OFS_CONTROL) begin
            ctl_next = WDATA;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctl_reg <= RST_CONTROL;
        end else begin
            ctl_reg <= ctl_next;
        end
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    // Receiver enable follows its control bit
    rx_gate_a: assert property (RX_ENABLE == ctl_reg[CTL_RX_ON])
        else $error("receiver enable differs from control bit");
    // No transmit-end request while its enable is clear
    irq_gate_a: assert property (!ctl_reg[CTL_TXD_IE] && !$past(ctl_reg[CTL_TXD_IE]) |-> !TX_DONE_IRQ)
        else $error("transmit-end request while disabled");
    // Transmitter off keeps the done flag set, so an enabled request shows
    irq_raise_a: assert property ((ctl_reg[CTL_TXD_IE] && !TX_ENABLE) [*3] |-> TX_DONE_IRQ)
        else $error("transmit-end request missing");
    // Transmitter off keeps the hold register empty
    tx_off_empty_a: assert property (!TX_ENABLE && !$past(TX_ENABLE) |-> !TX_DATA_VALID)
        else $error("hold data pending while transmitter off");
    // A hold write shows the data and marks it pending
    hold_write_a: assert property (WR && ADDR == OFS_TX_HOLD && TX_ENABLE && !TX_LOAD
        |=> TX_DATA == $past(WDATA) && TX_DATA_VALID)
        else $error("hold write not taken");
    // Shifter load empties the hold register
    load_empty_a: assert property (TX_LOAD && !(WR && ADDR == OFS_TX_HOLD) |=> !TX_DATA_VALID)
        else $error("hold still pending after load");
    // Pin is driven only for the clock-output codes of each mode
    sck_drive_a: assert property (SCK_OE && $stable(ctl_reg) && $stable(SYNC_MODE)
        |-> (SYNC_MODE ? ctl_reg[1:0] == CS_INT : ctl_reg[1:0] == CS_INT_OUT))
        else $error("clock pin driven for wrong code");
    // Idle generator: no ticks and clock held high
    gen_idle_a: assert property ((!TX_ENABLE && !RX_ENABLE && ctl_reg[1:0] != CS_EXT) [*3]
        |-> !BIT_TICK && SCK_OUT)
        else $error("rate generator active while idle");
    // Ticks are single-cycle pulses
    tick_pulse_a: assert property (BIT_TICK |=> !BIT_TICK)
        else $error("tick longer than one cycle");
    // Divisor reads back what was written
    div_back_a: assert property (WR && ADDR == OFS_DIVISOR ##1 !WR ##1 RD && ADDR == OFS_DIVISOR
        |=> RDATA == $past(WDATA, 3))
        else $error("divisor readback differs");

    load_seen_c: cover property (TX_LOAD ##1 !TX_DATA_VALID);
    irq_seen_c: cover property (TX_DONE_IRQ);
    pin_tick_c: cover property (SCK_OE && BIT_TICK);
endmodule : spcs_assertions

bind spcs_top spcs_assertions u_chk (
    .SYS_CLK(SYS_CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .TX_DATA(TX_DATA), .TX_DATA_VALID(TX_DATA_VALID), .TX_ENABLE(TX_ENABLE), .TX_LOAD(TX_LOAD),
    .RX_ENABLE(RX_ENABLE), .SYNC_MODE(SYNC_MODE), .BIT_TICK(BIT_TICK), .TX_DONE_IRQ(TX_DONE_IRQ),
    .SCK_OUT(SCK_OUT), .SCK_OE(SCK_OE)
);
`default_nettype wire

/* File: tb/spcs_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module spcs_peer (
    input  wire logic  clk,
    output logic       tx_load,
    output logic       tx_last,
    output logic       rx_done,
    output logic [7:0] rx_data,
    output logic       rx_mark,
    output logic       rx_ferr,
    output logic       rx_perr,
    output logic       sck
);
    // Quiet shifter lines, clock pin idle high
    initial begin
        {tx_load, tx_last, rx_done, rx_mark, rx_ferr, rx_perr} = 6'h00;
        rx_data = 8'h00;
        sck = 1'b1;
    end

    // Transmit shifter takes the hold data, or reports its last bit
    task automatic shift(input logic last);
        @(posedge clk);
        tx_load <= !last;
        tx_last <= last;
        @(posedge clk);
        tx_load <= 1'b0;
        tx_last <= 1'b0;
        @(negedge clk);
    endtask : shift

    // Finished character; afterwards the lines show the inverse, not a held value
    task automatic recv(input logic [7:0] d, input logic m, input logic fe, input logic pe);
        @(posedge clk);
        rx_done <= 1'b1;
        {rx_data, rx_mark, rx_ferr, rx_perr} <= {d, m, fe, pe};
        @(posedge clk);
        rx_done <= 1'b0;
        {rx_data, rx_mark, rx_ferr, rx_perr} <= ~{d, m, fe, pe};
        @(negedge clk);
    endtask : recv

    // External clock burst, still and high outside it
    task automatic ext(input int n);
        repeat (n) begin
            @(posedge clk);
            sck <= 1'b0;
            repeat (4) @(posedge clk);
            sck <= 1'b1;
            repeat (3) @(posedge clk);
        end
        @(negedge clk);
    endtask : ext
endmodule : spcs_peer
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
    import spcs_pkg::*;
;
    logic              SYS_CLK = 1'b0;
    logic              RST_N, WR, RD, CE;
    logic [ADDR_W-1:0] ADDR;
    logic [7:0]        WDATA;
    logic [7:0]        RDATA, TX_DATA, RX_DATA, d, e;
    logic              TX_DATA_VALID, TX_MARKER, TX_ENABLE, TX_LOAD, TX_LAST_BIT, RX_ENABLE, RX_DONE;
    logic              RX_MARK_IN, RX_FRAME_ERR, RX_PARITY_ERR, SYNC_MODE, MARK_MODE, BIT_TICK;
    logic              TX_DONE_IRQ, SCK_IN, SCK_OUT, SCK_OE;
    logic [7:0]        rst_tab [8] = '{8'h00, 8'hff, 8'h00, 8'hff, 8'h84, 8'h00, 8'h00, 8'h00};
    integer            seed = 32'hdaf60558;
    int                mismatches = 0, total_checks = 0, ticks = 0, c;

    spcs_top DUT (
        .SYS_CLK(SYS_CLK), .RST_N(RST_N), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .TX_DATA(TX_DATA), .TX_DATA_VALID(TX_DATA_VALID), .TX_MARKER(TX_MARKER),
        .TX_ENABLE(TX_ENABLE), .TX_LOAD(TX_LOAD), .TX_LAST_BIT(TX_LAST_BIT), .RX_ENABLE(RX_ENABLE),
        .RX_DONE(RX_DONE), .RX_DATA(RX_DATA), .RX_MARK_IN(RX_MARK_IN), .RX_FRAME_ERR(RX_FRAME_ERR),
        .RX_PARITY_ERR(RX_PARITY_ERR), .SYNC_MODE(SYNC_MODE), .MARK_MODE(MARK_MODE),
        .BIT_TICK(BIT_TICK), .TX_DONE_IRQ(TX_DONE_IRQ), .SCK_IN(SCK_IN), .SCK_OUT(SCK_OUT), .SCK_OE(SCK_OE)
    );
    spcs_peer u_peer (
        .clk(SYS_CLK), .tx_load(TX_LOAD), .tx_last(TX_LAST_BIT), .rx_done(RX_DONE), .rx_data(RX_DATA),
        .rx_mark(RX_MARK_IN), .rx_ferr(RX_FRAME_ERR), .rx_perr(RX_PARITY_ERR), .sck(SCK_IN)
    );

    // Clock and tick counter
    always #2 SYS_CLK = ~SYS_CLK;
    always @(posedge SYS_CLK) if (BIT_TICK === 1'b1) ticks <= ticks + 1;

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    task automatic chkn(input logic [15:0] g, input logic [15:0] x);
        total_checks++;
        if (g !== x) begin
            mismatches++;
            $display("MISMATCH %0t value %h expected %h", $time, g, x);
        end
    endtask : chkn

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge SYS_CLK);
        ADDR <= a;
        WDATA <= v;
        WR <= 1'b1;
        @(posedge SYS_CLK);
        WR <= 1'b0;
        @(negedge SYS_CLK);
    endtask : wr

    // Register read compared against an expected byte
    task automatic rc(input logic [2:0] a, input logic [7:0] x);
        @(posedge SYS_CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge SYS_CLK);
        RD <= 1'b0;
        @(negedge SYS_CLK);
        chkn({8'h00, RDATA}, {8'h00, x});
    endtask : rc

    task automatic idle(input int n);
        repeat (n) @(negedge SYS_CLK);
    endtask : idle

    // Cycles between two ticks, bounded
    task automatic gap(output int c);
        int n;
        n = ticks;
        c = 0;
        while (ticks == n && c < 5000) begin
            @(negedge SYS_CLK);
            c++;
        end
        if (c >= 5000) begin
            mismatches++;
            summarize();
        end
    endtask : gap

    initial begin
        CE <= 1'b1;
        {RST_N, WR, RD, ADDR, WDATA} <= '0;
        repeat (8) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        for (int i = 0; i < 8; i++) if (i != 3) rc(3'(i), rst_tab[i]);
        wr(3'h6, 8'hff);
        rc(3'h6, 8'h00);
        repeat (3) begin
            d = $random(seed);
            wr(OFS_DIVISOR, d);
            rc(OFS_DIVISOR, d);
        end
        wr(OFS_STATUS, 8'hff);
        rc(OFS_STATUS, 8'h85);
        chkn(16'(TX_MARKER), 16'h1);
        wr(OFS_STATUS, 8'h84);
        $display("test registers ends");
        // Transmit hold handshake with the shifter
        wr(OFS_CONTROL, 8'h30);
        chkn(16'({TX_ENABLE, RX_ENABLE}), 16'h3);
        d = $random(seed);
        wr(OFS_TX_HOLD, d);
        chkn({8'h00, TX_DATA}, {8'h00, d});
        rc(OFS_STATUS, 8'h00);
        u_peer.shift(1'b0);
        rc(OFS_STATUS, 8'h80);
        u_peer.shift(1'b1);
        rc(OFS_STATUS, 8'h84);
        wr(OFS_STATUS, 8'h00);
        rc(OFS_STATUS, 8'h00);
        chkn(16'(TX_DATA_VALID), 16'h1);
        u_peer.shift(1'b0);
        u_peer.shift(1'b1);
        $display("test transmit ends");
        // Reception, hold read, overrun
        d = $random(seed);
        e = $random(seed);
        u_peer.recv(d, 1'b1, 1'b0, 1'b0);
        rc(OFS_STATUS, 8'hc6);
        rc(OFS_RX_HOLD, d);
        rc(OFS_STATUS, 8'h86);
        u_peer.recv(d, 1'b0, 1'b0, 1'b0);
        u_peer.recv(e, 1'b0, 1'b0, 1'b0);
        rc(OFS_STATUS, 8'he4);
        wr(OFS_STATUS, 8'h84);
        rc(OFS_STATUS, 8'h84);
        rc(OFS_RX_HOLD, d);
        // Framing then parity: clearing needs a prior read showing the flag
        for (int k = 0; k < 2; k++) begin
            e = k ? 8'h08 : 8'h10;
            d = $random(seed);
            rc(OFS_STATUS, 8'h84);
            u_peer.recv(d, 1'b0, k == 0, k == 1);
            wr(OFS_STATUS, 8'h84);
            rc(OFS_STATUS, 8'h84 | e);
            rc(OFS_RX_HOLD, d);
            wr(OFS_STATUS, 8'h84);
            rc(OFS_STATUS, 8'h84);
        end
        // Receiver off keeps flags and marker
        u_peer.recv(d, 1'b1, 1'b0, 1'b0);
        rc(OFS_RX_HOLD, d);
        wr(OFS_CONTROL, 8'h20);
        u_peer.recv(~d, 1'b0, 1'b0, 1'b0);
        rc(OFS_STATUS, 8'h86);
        rc(OFS_RX_HOLD, d);
        // Address wait drops marker-0 characters
        wr(OFS_FORMAT, 8'h04);
        chkn(16'(MARK_MODE), 16'h1);
        wr(OFS_CONTROL, 8'h38);
        u_peer.recv(d, 1'b0, 1'b1, 1'b0);
        rc(OFS_STATUS, 8'h84);
        e = $random(seed);
        u_peer.recv(e, 1'b1, 1'b0, 1'b0);
        rc(OFS_CONTROL, 8'h30);
        rc(OFS_STATUS, 8'hc6);
        rc(OFS_RX_HOLD, e);
        wr(OFS_FORMAT, 8'h00);
        $display("test receive ends");
        // Transmit-end request
        wr(OFS_CONTROL, 8'h24);
        wr(OFS_TX_HOLD, d);
        idle(3);
        chkn(16'(TX_DONE_IRQ), 16'h0);
        u_peer.shift(1'b0);
        u_peer.shift(1'b1);
        idle(3);
        chkn(16'(TX_DONE_IRQ), 16'h1);
        wr(OFS_CONTROL, 8'h20);
        idle(3);
        chkn(16'(TX_DONE_IRQ), 16'h0);
        // Transmitter off sets the done flag, so an enabled request shows
        wr(OFS_CONTROL, 8'h04);
        idle(3);
        chkn(16'(TX_DONE_IRQ), 16'h1);
        $display("test interrupt ends");
        // Tick spacing for every mode and prescaler code
        for (int s = 0; s < 2; s++) for (int p = 0; p < 4; p++) begin
            d = $random(seed) & 8'h03;
            wr(OFS_FORMAT, {s[0], 5'h00, p[1:0]});
            wr(OFS_DIVISOR, d);
            wr(OFS_CONTROL, 8'h20);
            gap(c);
            gap(c);
            chkn(16'(c), 16'((d + 1) * (s ? 4 : 2) * (1 << (2 * p))));
            chkn(16'(SYNC_MODE), 16'(s));
            chkn(16'(SCK_OE), 16'(s));
            wr(OFS_CONTROL, 8'h00);
        end
        // Clock-source codes, external clock counted in ticks
        for (int k = 1; k < 8; k++) if (k != 4) begin
            wr(OFS_FORMAT, {k[2], 7'h00});
            wr(OFS_CONTROL, {6'h08, k[1:0]});
            idle(3);
            chkn(16'(SCK_OE), 16'(k == 1));
            if (k[1:0] == 2'b10) begin
                c = ticks;
                u_peer.ext(5);
                idle(8);
                chkn(16'(ticks - c), 16'h5);
            end
        end
        // Clock enable low freezes the generator between ticks, then it resumes
        wr(OFS_CONTROL, 8'h20);
        gap(c);
        @(posedge SYS_CLK) CE <= 1'b0;
        c = ticks;
        idle(40);
        chkn(16'(ticks - c), 16'h0);
        @(posedge SYS_CLK) CE <= 1'b1;
        gap(c);
        gap(c);
        chkn(16'(c), 16'((d + 1) * 4));
        wr(OFS_CONTROL, 8'h00);
        $display("test clocking ends");
        summarize();
    end
endmodule : tb
`default_nettype wire
